// [pvc_calibration.sv]
// Function
// - Seven-bit trim in bits 6:0, written by the search and by software.
// - Three-bit settle select in bits 6:4, reset 0x4; larger means longer wait.
// - With enable set, search starts when synthesizer reset is written from 1 to 0.
// - Search tunes trim so the oscillator frequency is centred.
// - Done bit 0 reads 1 after search ends or is skipped; resets to 0.
module pvc_calibration
#(
    parameter int SETTLE_BASE = pvc_pkg::SETTLE_BASE_CYC
)
(
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    // Oscillator side
    input  wire logic        osc_fast_in,
    output logic      [6:0]  osc_trim_out,
    output logic             synth_reset_out,
    output logic             cal_busy_out,
    output logic             cal_done_out
);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic                     wr_trim;
    logic                     wr_reset;
    logic                     wr_ctrl;
    logic                     synth_reset_r;
    logic [2:0]               settle_sel_r;
    logic                     cal_enable_r;
    logic [6:0]               trim_r;
    logic                     done_r;
    logic [2:0]               bit_idx_r;
    logic [pvc_pkg::SETTLE_CNT_W-1:0] settle_cnt_r;
    logic [pvc_pkg::SETTLE_CNT_W-1:0] settle_lim;
    logic                     start;
    logic                     release_reset;
    logic                     settle_end;
    logic                     hold_reset;
    pvc_pkg::pvc_state_e      state_r;

    assign wr_trim  = reg_wr_in && (reg_addr_in == pvc_pkg::OSC_TRIM_OFS);
    assign wr_reset = reg_wr_in && (reg_addr_in == pvc_pkg::SYNTH_RESET_OFS);
    assign wr_ctrl  = reg_wr_in && (reg_addr_in == pvc_pkg::CAL_CONTROL_OFS);

    // Only a 1-to-0 transition of the reset bit counts as a release
    assign release_reset = wr_reset && synth_reset_r
                           && !reg_wdata_in[pvc_pkg::SYNTH_RESET_BIT];
    assign start         = release_reset && cal_enable_r;
    // Next value of the reset bit: an abort acts at its write, not a cycle later
    assign hold_reset    = wr_reset ? reg_wdata_in[pvc_pkg::SYNTH_RESET_BIT]
                                    : synth_reset_r;

    // ------------------------------------------------------------
    // Synthesizer reset and calibration control
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            synth_reset_r <= pvc_pkg::SYNTH_RESET_RST;
        end
        else if (wr_reset)
        begin
            synth_reset_r <= reg_wdata_in[pvc_pkg::SYNTH_RESET_BIT];
        end
    end

    // Control is taken at any time; keeping it still outside reset is up to software
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            settle_sel_r <= pvc_pkg::SETTLE_SEL_RST;
            cal_enable_r <= pvc_pkg::CAL_ENABLE_RST;
        end
        else if (wr_ctrl)
        begin
            settle_sel_r <= reg_wdata_in[pvc_pkg::SETTLE_MSB:pvc_pkg::SETTLE_LSB];
            cal_enable_r <= reg_wdata_in[pvc_pkg::CAL_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Search state machine
    // ------------------------------------------------------------
    // Wait doubles per settle step: base, 2x base ... 128x base
    assign settle_lim = SETTLE_BASE[pvc_pkg::SETTLE_CNT_W-1:0] << settle_sel_r;
    assign settle_end = (settle_cnt_r == settle_lim - 1'b1);

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r      <= pvc_pkg::PVC_IDLE;
            bit_idx_r    <= pvc_pkg::TRIM_TOP_BIT;
            settle_cnt_r <= '0;
        end
        else if (hold_reset)
        begin
            // Setting the reset bit aborts a running search at once
            state_r      <= pvc_pkg::PVC_IDLE;
            settle_cnt_r <= '0;
        end
        else
        begin
            case (state_r)
                pvc_pkg::PVC_IDLE:
                begin
                    if (start)
                    begin
                        state_r      <= pvc_pkg::PVC_SETTLE;
                        bit_idx_r    <= pvc_pkg::TRIM_TOP_BIT;
                        settle_cnt_r <= '0;
                    end
                end
                pvc_pkg::PVC_SETTLE:
                begin
                    settle_cnt_r <= settle_cnt_r + 1'b1;
                    if (settle_end)
                    begin
                        state_r <= pvc_pkg::PVC_EVAL;
                    end
                end
                pvc_pkg::PVC_EVAL:
                begin
                    settle_cnt_r <= '0;
                    if (bit_idx_r == 3'h0)
                    begin
                        state_r <= pvc_pkg::PVC_IDLE;
                    end
                    else
                    begin
                        state_r   <= pvc_pkg::PVC_SETTLE;
                        bit_idx_r <= bit_idx_r - 1'b1;
                    end
                end
                default:
                begin
                    state_r <= pvc_pkg::PVC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frequency trim
    // ------------------------------------------------------------
    // Engine owns the trim while busy; a software write then is dropped
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            trim_r <= pvc_pkg::TRIM_RST;
        end
        else if (start)
        begin
            trim_r <= pvc_pkg::TRIM_MIDSCALE;
        end
        else if (state_r == pvc_pkg::PVC_EVAL && !hold_reset)
        begin
            // Successive approximation: drop the bit if too fast, try the next one
            if (osc_fast_in)
            begin
                trim_r[bit_idx_r] <= 1'b0;
            end
            if (bit_idx_r != 3'h0)
            begin
                trim_r[bit_idx_r - 1'b1] <= 1'b1;
            end
        end
        else if (wr_trim && state_r == pvc_pkg::PVC_IDLE)
        begin
            trim_r <= reg_wdata_in[6:0];
        end
    end

    // ------------------------------------------------------------
    // Done flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            done_r <= 1'b0;
        end
        else if (release_reset)
        begin
            done_r <= !cal_enable_r;
        end
        // An abort in the last eval cycle cancels that eval, so no done is reported
        else if (state_r == pvc_pkg::PVC_EVAL && bit_idx_r == 3'h0 && !hold_reset)
        begin
            done_r <= 1'b1;
        end
        else if (wr_reset && reg_wdata_in[pvc_pkg::SYNTH_RESET_BIT])
        begin
            done_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                pvc_pkg::OSC_TRIM_OFS:    reg_rdata_out <= {1'b0, trim_r};
                pvc_pkg::SYNTH_RESET_OFS: reg_rdata_out <= {7'h00, synth_reset_r};
                pvc_pkg::CAL_CONTROL_OFS: reg_rdata_out <= {1'b0, settle_sel_r, 3'h0,
                                                            cal_enable_r};
                pvc_pkg::CAL_STATUS_OFS:  reg_rdata_out <= {7'h00, done_r};
                default:                  reg_rdata_out <= 8'h00;
            endcase
        end
    end

    assign osc_trim_out    = trim_r;
    assign synth_reset_out = synth_reset_r;
    assign cal_busy_out    = (state_r != pvc_pkg::PVC_IDLE);
    assign cal_done_out    = done_r;

endmodule

// [pvc_calibration_props.sv]
module pvc_calibration_props
#(
    parameter int SETTLE_BASE = 16
)
(
    input wire logic       clk_in,
    input wire logic       arst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       osc_fast_in,
    input wire logic [6:0] osc_trim_out,
    input wire logic       synth_reset_out,
    input wire logic       cal_busy_out,
    input wire logic       cal_done_out
);
    // ------------------------------------------------------------
    // Enable shadow, taken from control writes
    // ------------------------------------------------------------
    logic en_r;
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            en_r <= 1'b0;
        else if (reg_wr_in && reg_addr_in == 8'h5d)
            en_r <= reg_wdata_in[0];
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    a_status_read: assert property
        (reg_rd_in && reg_addr_in == 8'h5e |=> reg_rdata_out == {7'h00, $past(cal_done_out)})
        else $error("status read");
    a_unmapped_read: assert property
        (reg_rd_in && !(reg_addr_in inside {8'h59, 8'h5c, 8'h5d, 8'h5e}) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read");
    a_rdata_holds: assert property
        (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    a_synth_write: assert property
        (reg_wr_in && reg_addr_in == 8'h5c |=> synth_reset_out == $past(reg_wdata_in[0]))
        else $error("reset bit");
    a_start_search: assert property
        (reg_wr_in && reg_addr_in == 8'h5c && !reg_wdata_in[0] && synth_reset_out && en_r
         |=> cal_busy_out && osc_trim_out == 7'h40 && !cal_done_out)
        else $error("search start");
    a_skip_done: assert property
        (reg_wr_in && reg_addr_in == 8'h5c && !reg_wdata_in[0] && synth_reset_out && !en_r
         |=> ##[0:1] cal_done_out && !cal_busy_out)
        else $error("skip done");
    a_done_clears: assert property
        (reg_wr_in && reg_addr_in == 8'h5c && reg_wdata_in[0] |=> !cal_done_out && !cal_busy_out)
        else $error("abort");
    a_trim_write: assert property
        (reg_wr_in && reg_addr_in == 8'h59 && !cal_busy_out |=> osc_trim_out == $past(reg_wdata_in[6:0]))
        else $error("trim write");
    c_search: cover property ($fell(cal_busy_out) && cal_done_out);
    c_fast: cover property (cal_busy_out && osc_fast_in);
    c_restore: cover property (reg_wr_in && reg_addr_in == 8'h59 && !cal_busy_out);
endmodule

bind pvc_calibration pvc_calibration_props #(.SETTLE_BASE(SETTLE_BASE)) u_props (.*);

// [pvc_pkg.sv]
package pvc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OSC_TRIM_OFS      = 8'h59;
    localparam logic [7:0] SYNTH_RESET_OFS   = 8'h5c;
    localparam logic [7:0] CAL_CONTROL_OFS   = 8'h5d;
    localparam logic [7:0] CAL_STATUS_OFS    = 8'h5e;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [6:0] TRIM_RST          = 7'h00;
    localparam logic       SYNTH_RESET_RST   = 1'b0;
    localparam logic [2:0] SETTLE_SEL_RST    = 3'h4;
    localparam logic       CAL_ENABLE_RST    = 1'b0;
    localparam int         SETTLE_LSB        = 4;
    localparam int         SETTLE_MSB        = 6;
    localparam int         CAL_ENABLE_BIT    = 0;
    localparam int         SYNTH_RESET_BIT   = 0;
    localparam int         CAL_DONE_BIT      = 0;

    // ------------------------------------------------------------
    // Search and timing
    // ------------------------------------------------------------
    localparam logic [6:0] TRIM_MIDSCALE     = 7'h40;
    localparam logic [2:0] TRIM_TOP_BIT      = 3'h6;
    localparam int         SETTLE_BASE_CYC   = 16;
    localparam int         SETTLE_CNT_W      = 12;

    typedef enum logic [1:0]
    {
        PVC_IDLE   = 2'b00,
        PVC_SETTLE = 2'b01,
        PVC_EVAL   = 2'b11
    } pvc_state_e;

endpackage

// [tb_pll_vco_calibration_control.sv]
module tb_pll_vco_calibration_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 1'b0;
    logic       arst_n_in = 1'b0;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic       osc_fast_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] reg_rdata_out;
    logic [6:0] osc_trim_out;
    logic       synth_reset_out;
    logic       cal_busy_out;
    logic       cal_done_out;
    logic [6:0] target = 7'h00;
    int         mismatches = 0;
    int         comparisons = 0;
    int         n = 0;
    int         last = 0;
    // ------------------------------------------------------------
    // Clock, comparator model and design
    // ------------------------------------------------------------
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in)
        #1 osc_fast_in = (osc_trim_out > target);
    pvc_calibration #(.SETTLE_BASE(2)) dut (
        .clk_in          (clk_in),
        .arst_n_in       (arst_n_in),
        .reg_addr_in     (reg_addr_in),
        .reg_wr_in       (reg_wr_in),
        .reg_rd_in       (reg_rd_in),
        .reg_wdata_in    (reg_wdata_in),
        .reg_rdata_out   (reg_rdata_out),
        .osc_fast_in     (osc_fast_in),
        .osc_trim_out    (osc_trim_out),
        .synth_reset_out (synth_reset_out),
        .cal_busy_out    (cal_busy_out),
        .cal_done_out    (cal_done_out)
    );
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge clk_in);
        #1 reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        #1;
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(posedge clk_in);
        #1 reg_rd_in = 1'b0;
        check(reg_rdata_out, exp);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded wait; a hang ends the run as a failure
    task automatic wait_done();
        n = 0;
        while (cal_done_out !== 1'b1 && n < 4000)
        begin
            @(posedge clk_in);
            #1 n++;
        end
        if (n >= 4000)
        begin
            mismatches++;
            complete_run();
        end
    endtask
    initial
    begin
        repeat (3) @(posedge clk_in);
        #1 arst_n_in = 1'b1;
        rd(8'h59, 8'h00);
        rd(8'h5c, 8'h00);
        rd(8'h5d, 8'h40);
        rd(8'h5e, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h5e, 8'hff);
        rd(8'h5e, 8'h00);
        $display("test reset values done");
        wr(8'h5c, 8'h01);
        wr(8'h5d, 8'h40);
        wr(8'h5c, 8'h00);
        @(posedge clk_in);
        rd(8'h5e, 8'h01);
        $display("test skipped search done");
        for (int i = 0; i < 3; i++)
        begin
            target = (i == 0) ? 7'h35 : ((i == 1) ? 7'h7f : 7'h00);
            wr(8'h5c, 8'h01);
            check({7'h00, cal_done_out}, 8'h00);
            check({7'h00, synth_reset_out}, 8'h01);
            wr(8'h5d, {1'b0, 3'(i * 3), 4'h1});
            wr(8'h5c, 8'h00);
            check({cal_busy_out, osc_trim_out}, 8'hc0);
            wait_done();
            check({7'h00, 1'(n > last)}, 8'h01);
            last = n;
            rd(8'h59, {1'b0, target});
            rd(8'h5e, 8'h01);
        end
        $display("test search done");
        wr(8'h5c, 8'h01);
        wr(8'h5d, 8'h71);
        wr(8'h5c, 8'h00);
        wr(8'h5c, 8'h01);
        check({6'h00, cal_busy_out, cal_done_out}, 8'h00);
        wr(8'h59, 8'h2a);
        rd(8'h59, 8'h2a);
        $display("test abort and restore done");
        complete_run();
    end
endmodule
